// *** src/ext_bus_pkg.sv ***
package ext_bus_pkg;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam int AREAS  = 4;
    // external chip-select windows, inclusive bounds; anything else is on-chip memory
    localparam logic [19:0] AREA_LO [4] = '{20'h08000, 20'h28000, 20'h30000, 20'h40000};
    localparam logic [19:0] AREA_HI [4] = '{20'h27FFF, 20'h2FFFF, 20'h3FFFF, 20'hBFFFF};
    localparam logic [2:0]  WAIT_BASE   = 3'h1;
    localparam logic [2:0]  INT_WAIT    = 3'h1;
    localparam logic [2:0]  NO_WAIT     = 3'h0;
    localparam logic [15:0] DATA_RST    = 16'h0000;
    localparam logic [19:0] ADDR_RST    = 20'h00000;
    localparam logic [3:0]  CS_IDLE     = 4'hF;
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_STROBE, ST_INTERNAL, ST_HOLD} bus_state_t;
endpackage : ext_bus_pkg

// *** src/external_bus_control.sv ***
`timescale 1ns/1ps
`default_nettype none
// How it works
// - each chip-select pin is a port pin or a low chip select per control bit
// - four address windows each drive their own chip-select output
// - wait-disable low adds one wait plus the area's two-bit count field
// - access to another area updates both address and chip selects
// - external then internal access releases chip select, keeps the address
// - same area twice updates the address, chip select stays low
// - an idle cycle leaves address and chip selects untouched
// - 16-bit bus chooses byte-enable or split-write strobes; 8-bit uses byte-enable
// - split style: low write strobe per byte lane, read strobe for reads
// - byte-enable style: high enable and address bit zero pick the lanes
// - 8-bit bus moves one byte per access, high enable unused
// - ready low at the last bus-clock fall inserts one wait state
// - all bus outputs except the bus clock freeze during a ready wait
// - ready seen high at a fall lets the cycle finish
// - hold request waits for the current access, then hold lasts while low
// - grant output is low throughout the hold state
// - bus priority: hold request, then dma controller, then processor
// - dma is locked out between the two halves of a split word
// - 16-bit multiplexed bus puts address bits 1 to 8 on data 0 to 7
// - hold state floats address, data, chip selects and strobes; clock keeps running
module external_bus_control (
    input  wire logic        clk_sys_i,                // system clock
    input  wire logic        srst_i,                   // synchronous reset
    input  wire logic [3:0]  area_select_control_i,    // per pin: 1 chip select, 0 port
    input  wire logic [3:0]  port_out_i,               // port levels for pins not in chip-select use
    input  wire logic [3:0]  area_wait_disable_i,      // per area: 1 no waits
    input  wire logic [7:0]  area_wait_count_field_i,  // two bits per area
    input  wire logic        internal_wait_insert_i,   // wait on on-chip accesses
    input  wire logic        strobe_style_select_i,    // 1 split write strobes
    input  wire logic        byte_mode_i,              // 1 8-bit data bus
    input  wire logic [3:0]  mux_area_i,               // per area: multiplexed bus
    input  wire logic        cpu_req_i,                // processor request, held to ack
    input  wire logic        cpu_we_i,                 // processor write
    input  wire logic        cpu_word_i,               // processor word access
    input  wire logic [19:0] cpu_addr_i,               // processor address
    input  wire logic [15:0] cpu_wdata_i,              // processor write data
    output var  logic        cpu_ack_o,                // processor done pulse
    input  wire logic        dma_req_i,                // dma request, held to ack
    input  wire logic        dma_we_i,                 // dma write
    input  wire logic        dma_word_i,               // dma word access
    input  wire logic [19:0] dma_addr_i,               // dma address
    input  wire logic [15:0] dma_wdata_i,              // dma write data
    output var  logic        dma_ack_o,                // dma done pulse
    output var  logic [15:0] rdata_o,                  // read data of last external read
    output var  logic        bclk_o,                   // bus clock
    output var  logic [19:0] addr_o,                   // address pins
    output var  logic        addr_oe_o,                // address drive enable
    output var  logic [15:0] data_o,                   // data pins out
    output var  logic        data_oe_o,                // data drive enable
    input  wire logic [15:0] data_i,                   // data pins in
    output var  logic [3:0]  cs_n_o,                   // chip-select / port pins
    output var  logic        cs_oe_o,                  // chip-select pin drive enable
    output var  logic        rd_n_o,                   // read strobe
    output var  logic        low_byte_write_n_o,       // low-byte write, or write strobe
    output var  logic        high_byte_write_n_o,      // high-byte write, or high_byte_enable_n
    output var  logic        strobe_oe_o,              // strobe drive enable
    output var  logic        ale_o,                    // address latch strobe
    input  wire logic        rdy_n_i,                  // ready, low = not ready
    input  wire logic        hold_n_i,                 // hold request, low active
    output var  logic        bus_grant_n_o             // hold acknowledge, low active
);
    ext_bus_pkg::bus_state_t state;
    logic        fall_en;
    logic        rdy_meta, rdy_sync, hold_meta, hold_sync;
    logic [3:0]  area_cs_n;
    logic        cur_we, cur_dma, cur_split, half, pend, lo_en, hi_en, cur_mux;
    logic [19:0] base_addr;
    logic [15:0] cur_wdata;
    logic [2:0]  wcnt;
    logic        sel_valid, sel_dma, sel_we, sel_word;
    logic [19:0] sel_addr;
    logic [15:0] sel_wdata;
    logic [3:0]  sel_area;

    function automatic logic [3:0] area_of(input logic [19:0] a);
        logic [3:0] hit;
        hit = '0;
        for (int i = 0; i < ext_bus_pkg::AREAS; i++) begin
            hit[i] = (a >= ext_bus_pkg::AREA_LO[i]) && (a <= ext_bus_pkg::AREA_HI[i]);
        end
        return hit;
    endfunction : area_of

    function automatic logic [2:0] waits_of(input logic [3:0] hit, input logic [3:0] dis,
                                            input logic [7:0] cnt);
        logic [2:0] w;
        w = ext_bus_pkg::NO_WAIT;
        for (int i = 0; i < ext_bus_pkg::AREAS; i++) begin
            if (hit[i] && !dis[i]) begin
                w = ext_bus_pkg::WAIT_BASE + {1'b0, cnt[2*i +: 2]};
            end
        end
        return w;
    endfunction : waits_of

    // returns {read, low write / write, high write / high enable}, all low active
    function automatic logic [2:0] strobes_of(input logic we, input logic lo, input logic hi,
                                              input logic split, input logic bytem);
        logic [2:0] s;
        if (split && !bytem) begin
            s = {we, !(we && lo), !(we && hi)};
        end else begin
            s = {we, !we, bytem ? 1'b1 : !hi};
        end
        return s;
    endfunction : strobes_of

    // bus clock at half the system rate; state moves on its falling edges
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            bclk_o <= 1'b0;
        end else begin
            bclk_o <= ~bclk_o;
        end
    end
    assign fall_en = bclk_o;

    // two flops on the ready and hold pin inputs before the bus state machine reads them; data_i is read directly
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            rdy_meta  <= 1'b1;
            rdy_sync  <= 1'b1;
            hold_meta <= 1'b1;
            hold_sync <= 1'b1;
        end else begin
            rdy_meta  <= rdy_n_i;
            rdy_sync  <= rdy_meta;
            hold_meta <= hold_n_i;
            hold_sync <= hold_meta;
        end
    end

    // pending second half outranks dma, dma outranks the processor
    always_comb begin
        sel_dma   = dma_req_i && !pend;
        sel_valid = pend || dma_req_i || cpu_req_i;
        sel_we    = pend ? cur_we : (sel_dma ? dma_we_i : cpu_we_i);
        sel_word  = sel_dma ? dma_word_i : cpu_word_i;
        sel_wdata = sel_dma ? dma_wdata_i : cpu_wdata_i;
        sel_addr  = pend ? base_addr + 20'h00001 : (sel_dma ? dma_addr_i : cpu_addr_i);
        sel_area  = area_of(sel_addr);
    end

    // bus cycle: address phase, strobe phase with counted then ready waits, one ack per request
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            state               <= ext_bus_pkg::ST_IDLE;
            addr_o              <= ext_bus_pkg::ADDR_RST;
            data_o              <= ext_bus_pkg::DATA_RST;
            data_oe_o           <= 1'b0;
            rdata_o             <= ext_bus_pkg::DATA_RST;
            area_cs_n           <= ext_bus_pkg::CS_IDLE;
            {rd_n_o, low_byte_write_n_o, high_byte_write_n_o} <= 3'h7;
            ale_o               <= 1'b0;
            bus_grant_n_o       <= 1'b1;
            addr_oe_o           <= 1'b1;
            strobe_oe_o         <= 1'b1;
            cpu_ack_o           <= 1'b0;
            dma_ack_o           <= 1'b0;
            cur_we              <= 1'b0;
            cur_dma             <= 1'b0;
            cur_split           <= 1'b0;
            cur_mux             <= 1'b0;
            half                <= 1'b0;
            pend                <= 1'b0;
            lo_en               <= 1'b0;
            hi_en               <= 1'b0;
            base_addr           <= ext_bus_pkg::ADDR_RST;
            cur_wdata           <= ext_bus_pkg::DATA_RST;
            wcnt                <= ext_bus_pkg::NO_WAIT;
        end else begin
            cpu_ack_o <= 1'b0;
            dma_ack_o <= 1'b0;
            if (fall_en) begin
                unique case (state)
                    ext_bus_pkg::ST_IDLE: begin
                        if (!hold_sync) begin
                            state         <= ext_bus_pkg::ST_HOLD;
                            bus_grant_n_o <= 1'b0;
                            addr_oe_o     <= 1'b0;
                            strobe_oe_o   <= 1'b0;
                            data_oe_o     <= 1'b0;
                        end else if (sel_valid) begin
                            if (!pend) begin
                                cur_dma   <= sel_dma;
                                cur_we    <= sel_we;
                                cur_wdata <= sel_wdata;
                                base_addr <= sel_addr;
                                cur_split <= sel_word && (sel_addr[0] || byte_mode_i);
                                half      <= 1'b0;
                                lo_en     <= byte_mode_i || !sel_addr[0] || (sel_word && !sel_addr[0]);
                                hi_en     <= !byte_mode_i && (sel_addr[0] || sel_word);
                            end else begin
                                // second half: next byte address, lanes follow its low bit
                                half      <= 1'b1;
                                lo_en     <= byte_mode_i || !sel_addr[0];
                                hi_en     <= !byte_mode_i && sel_addr[0];
                            end
                            if (sel_area == 4'h0) begin
                                area_cs_n <= ext_bus_pkg::CS_IDLE;
                                wcnt      <= internal_wait_insert_i ? ext_bus_pkg::INT_WAIT
                                                                    : ext_bus_pkg::NO_WAIT;
                                state     <= ext_bus_pkg::ST_INTERNAL;
                            end else begin
                                addr_o    <= sel_addr;
                                area_cs_n <= ~sel_area;
                                wcnt      <= waits_of(sel_area, area_wait_disable_i,
                                                      area_wait_count_field_i);
                                cur_mux   <= |(sel_area & mux_area_i);
                                if (|(sel_area & mux_area_i)) begin
                                    ale_o     <= 1'b1;
                                    data_oe_o <= 1'b1;
                                    data_o    <= byte_mode_i ? {8'h00, sel_addr[7:0]}
                                                             : {8'h00, sel_addr[8:1]};
                                end
                                state     <= ext_bus_pkg::ST_ADDR;
                            end
                        end
                    end
                    ext_bus_pkg::ST_ADDR: begin
                        ale_o <= 1'b0;
                        {rd_n_o, low_byte_write_n_o, high_byte_write_n_o} <=
                            strobes_of(cur_we, lo_en, hi_en, strobe_style_select_i, byte_mode_i);
                        data_oe_o <= cur_we;
                        if (cur_split) begin
                            data_o <= half ? {2{cur_wdata[15:8]}} : {2{cur_wdata[7:0]}};
                        end else begin
                            data_o <= cur_wdata;
                        end
                        state <= ext_bus_pkg::ST_STROBE;
                    end
                    ext_bus_pkg::ST_STROBE: begin
                        if (wcnt != ext_bus_pkg::NO_WAIT) begin
                            wcnt <= wcnt - 3'h1;
                        // counted waits run out first; only then can ready stretch the cycle
                        end else if (rdy_sync) begin
                            {rd_n_o, low_byte_write_n_o, high_byte_write_n_o} <= 3'h7;
                            data_oe_o <= 1'b0;
                            if (!cur_we) begin
                                if (!cur_split) begin
                                    rdata_o <= (byte_mode_i || cur_mux) ? {8'h00, data_i[7:0]} : data_i;
                                end else if (half) begin
                                    rdata_o[15:8] <= (hi_en && !cur_mux) ? data_i[15:8] : data_i[7:0];
                                end else begin
                                    rdata_o[7:0]  <= (hi_en && !cur_mux) ? data_i[15:8] : data_i[7:0];
                                end
                            end
                            pend      <= cur_split && !half;
                            cpu_ack_o <= !cur_dma && !(cur_split && !half);
                            dma_ack_o <= cur_dma && !(cur_split && !half);
                            state     <= ext_bus_pkg::ST_IDLE;
                        end
                    end
                    ext_bus_pkg::ST_INTERNAL: begin
                        if (wcnt != ext_bus_pkg::NO_WAIT) begin
                            wcnt <= wcnt - 3'h1;
                        end else begin
                            pend      <= cur_split && !half;
                            cpu_ack_o <= !cur_dma && !(cur_split && !half);
                            dma_ack_o <= cur_dma && !(cur_split && !half);
                            state     <= ext_bus_pkg::ST_IDLE;
                        end
                    end
                    // grant and drive enables return on the fall after the request is gone
                    ext_bus_pkg::ST_HOLD: begin
                        if (hold_sync) begin
                            bus_grant_n_o <= 1'b1;
                            addr_oe_o     <= 1'b1;
                            strobe_oe_o   <= 1'b1;
                            state         <= ext_bus_pkg::ST_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // pin owner per bit; idle cycles leave area_cs_n and addr_o alone
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            cs_n_o  <= ext_bus_pkg::CS_IDLE;
            cs_oe_o <= 1'b1;
        end else begin
            for (int i = 0; i < ext_bus_pkg::AREAS; i++) begin
                cs_n_o[i] <= area_select_control_i[i] ? area_cs_n[i] : port_out_i[i];
            end
            // chip-select pins float on the same edge as the other bus pins
            cs_oe_o <= (state != ext_bus_pkg::ST_HOLD) && !(fall_en && state == ext_bus_pkg::ST_IDLE
                                                            && !hold_sync);
        end
    end
endmodule : external_bus_control
`default_nettype wire

// *** test/external_bus_control_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module external_bus_control_chk (
    input wire logic        clk_sys_i,
    input wire logic        srst_i,
    input wire logic [3:0]  area_select_control_i,
    input wire logic [3:0]  port_out_i,
    input wire logic        strobe_style_select_i,
    input wire logic        byte_mode_i,
    input wire logic        hold_n_i,
    input wire logic        cpu_ack_o,
    input wire logic        dma_ack_o,
    input wire logic [19:0] addr_o,
    input wire logic        addr_oe_o,
    input wire logic        data_oe_o,
    input wire logic        strobe_oe_o,
    input wire logic [3:0]  cs_n_o,
    input wire logic        rd_n_o,
    input wire logic        low_byte_write_n_o,
    input wire logic        high_byte_write_n_o,
    input wire logic        bus_grant_n_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    a_port_pin_level: assert property ((!area_select_control_i[3] && $stable(port_out_i[3]))[*3]
        ##0 !$past(srst_i, 2) |-> cs_n_o[3] == port_out_i[3]) else $error("port pin level wrong");
    a_single_cs: assert property ($onehot0(~cs_n_o & area_select_control_i)) else $error("two selects low");
    a_hold_float: assert property (!bus_grant_n_o |-> !addr_oe_o && !data_oe_o && !strobe_oe_o)
        else $error("bus driven in hold");
    a_grant_back: assert property (hold_n_i[*8] |-> bus_grant_n_o) else $error("grant kept low");
    a_rd_wr_apart: assert property (strobe_oe_o |-> rd_n_o || low_byte_write_n_o) else $error("read and write");
    a_split_lanes: assert property (strobe_style_select_i && !byte_mode_i && strobe_oe_o
        && (low_byte_write_n_o != high_byte_write_n_o) |-> addr_o[0] == low_byte_write_n_o) else $error("bad lane");
    a_enable_lanes: assert property (!strobe_style_select_i && !byte_mode_i && strobe_oe_o
        && !(rd_n_o && low_byte_write_n_o) && high_byte_write_n_o |-> !addr_o[0]) else $error("bad byte enable");
    a_strobe_freeze: assert property (!rd_n_o && $past(!rd_n_o) |-> $stable(addr_o) && $stable(cs_n_o))
        else $error("moved in strobe");
    a_strobe_ends: assert property ($fell(rd_n_o) |-> ##[1:100] rd_n_o) else $error("strobe stuck");
    a_one_owner: assert property (cpu_ack_o |-> !dma_ack_o ##1 !cpu_ack_o) else $error("double ack");
    c_hold: cover property (!bus_grant_n_o);
    c_dma: cover property (dma_ack_o);
    c_stall: cover property ($fell(rd_n_o) ##[6:40] $rose(rd_n_o));
endmodule : external_bus_control_chk
bind external_bus_control external_bus_control_chk i_external_bus_control_chk (.clk_sys_i(clk_sys_i),
    .srst_i(srst_i), .area_select_control_i(area_select_control_i), .port_out_i(port_out_i),
    .strobe_style_select_i(strobe_style_select_i), .byte_mode_i(byte_mode_i), .hold_n_i(hold_n_i),
    .cpu_ack_o(cpu_ack_o), .dma_ack_o(dma_ack_o), .addr_o(addr_o), .addr_oe_o(addr_oe_o), .data_oe_o(data_oe_o),
    .strobe_oe_o(strobe_oe_o), .cs_n_o(cs_n_o), .rd_n_o(rd_n_o), .low_byte_write_n_o(low_byte_write_n_o),
    .high_byte_write_n_o(high_byte_write_n_o), .bus_grant_n_o(bus_grant_n_o));
`default_nettype wire

// *** test/ext_bus_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
module ext_bus_partner (
    input  wire logic        clk_sys_i,  // system clock
    input  wire logic [19:0] addr_i,     // address pins
    input  wire logic [15:0] wdata_i,    // data from device
    input  wire logic        rd_n_i,     // read strobe
    input  wire logic        wrl_n_i,    // low write or write strobe
    input  wire logic        wrh_n_i,    // high write or high enable
    input  wire logic        split_i,    // split write strobes
    input  wire logic        byte_i,     // 8-bit bus
    input  wire logic [3:0]  stall_i,    // ready-low clocks per strobe
    output var  logic [15:0] rdata_o,    // data to device
    output var  logic        rdy_n_o     // ready
);
    logic [7:0]  mem [32];
    logic [3:0]  n_low;
    logic [15:0] last;
    logic [4:0]  e;
    logic        act, lo, hi;
    assign e   = {addr_i[4:1], 1'b0};
    assign act = !rd_n_i || !wrl_n_i || (split_i && !wrh_n_i);
    assign lo  = split_i ? !wrl_n_i : !wrl_n_i && !addr_i[0];
    assign hi  = split_i ? !wrh_n_i : !wrl_n_i && !wrh_n_i;
    // pulled up unless stretching the current strobe
    assign rdy_n_o = !(act && n_low < stall_i);
    // released data lines show a changing pattern, never the last value
    assign rdata_o = rd_n_i ? ~last : byte_i ? {2{mem[addr_i[4:0]]}} : {mem[e + 5'h01], mem[e]};
    always @(posedge clk_sys_i) begin
        n_low <= act ? n_low + 4'(n_low != 4'hF) : 4'h0;
        last  <= rdata_o;
        if (byte_i && !wrl_n_i) mem[addr_i[4:0]] <= wdata_i[7:0];
        if (!byte_i && lo) mem[e] <= wdata_i[7:0];
        if (!byte_i && hi) mem[e + 5'h01] <= wdata_i[15:8];
    end
endmodule : ext_bus_partner
`default_nettype wire

// *** test/external_bus_control_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module external_bus_control_bench;
    logic        clk_sys_i, srst_i, int_wait, split, bytem, cpu_req, dma_req, we, word, hold_n, rdy_n;
    logic        cpu_ack, dma_ack, bclk, a_oe, d_oe, cs_oe, rd_n, wrl_n, wrh_n, s_oe, ale, grant_n, first;
    logic [3:0]  sel_ctl, port_out, wait_dis, stall, cs_n, mux;
    logic [7:0]  wait_cnt;
    logic [19:0] addr, a_o;
    logic [15:0] wdata, rdata, d_o, din, got, mux_addr;
    int          n_mismatch, n_compared, cycles, lat, l0, l1, hold_cnt;
    external_bus_control i_external_bus_control (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .area_select_control_i(sel_ctl), .port_out_i(port_out), .area_wait_disable_i(wait_dis),
        .area_wait_count_field_i(wait_cnt), .internal_wait_insert_i(int_wait), .strobe_style_select_i(split),
        .byte_mode_i(bytem), .mux_area_i(mux), .cpu_req_i(cpu_req), .cpu_we_i(we), .cpu_word_i(word),
        .cpu_addr_i(addr), .cpu_wdata_i(wdata), .cpu_ack_o(cpu_ack), .dma_req_i(dma_req), .dma_we_i(we),
        .dma_word_i(word), .dma_addr_i(addr), .dma_wdata_i(wdata), .dma_ack_o(dma_ack), .rdata_o(rdata),
        .bclk_o(bclk), .addr_o(a_o), .addr_oe_o(a_oe), .data_o(d_o), .data_oe_o(d_oe), .data_i(din),
        .cs_n_o(cs_n), .cs_oe_o(cs_oe), .rd_n_o(rd_n), .low_byte_write_n_o(wrl_n), .high_byte_write_n_o(wrh_n),
        .strobe_oe_o(s_oe), .ale_o(ale), .rdy_n_i(rdy_n), .hold_n_i(hold_n), .bus_grant_n_o(grant_n));
    ext_bus_partner i_ext_bus_partner (.clk_sys_i(clk_sys_i), .addr_i(a_o), .wdata_i(d_o), .rd_n_i(rd_n),
        .wrl_n_i(wrl_n), .wrh_n_i(wrh_n), .split_i(split), .byte_i(bytem), .stall_i(stall), .rdata_o(din),
        .rdy_n_o(rdy_n));
    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    // external master holds the bus while hold_cnt runs down; cycle ceiling cuts a hang
    always @(posedge clk_sys_i) begin
        hold_n <= (hold_cnt == 0);
        if (ale) mux_addr <= d_o;
        if (hold_cnt > 0) hold_cnt <= hold_cnt - 1;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end
    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic acc(input logic d, input logic w, input logic wd, input logic [19:0] a, input logic [15:0] v);
        @(posedge clk_sys_i);
        {cpu_req, dma_req, we, word, addr, wdata} <= {!d, d, w, wd, a, v};
        lat = 0;
        do begin
            @(negedge clk_sys_i);
            lat++;
        end while (!(cpu_ack || dma_ack) && lat < 300);
        if (!(cpu_ack || dma_ack)) n_mismatch++;
        got = rdata;
        @(posedge clk_sys_i);
        {cpu_req, dma_req} <= 2'h0;
    endtask : acc
    task automatic rw(input logic [19:0] a, input logic [15:0] v);
        acc(1'b0, 1'b1, 1'b1, a, v);
        acc(1'b0, 1'b0, 1'b1, a, 16'h0000);
        chk(20'(got), 20'(v));
    endtask : rw
    task automatic prio(input logic [19:0] a, input int gap, input logic exp);
        @(posedge clk_sys_i);
        {cpu_req, we, word, addr} <= {1'b1, 1'b0, 1'b1, a};
        repeat (gap) @(posedge clk_sys_i);
        dma_req <= 1'b1;
        do @(negedge clk_sys_i); while (!(cpu_ack || dma_ack));
        first = dma_ack;
        chk(20'(first), 20'(exp));
        @(posedge clk_sys_i);
        if (first) dma_req <= 1'b0; else cpu_req <= 1'b0;
        do @(negedge clk_sys_i); while (!(first ? cpu_ack : dma_ack));
        @(posedge clk_sys_i);
        {cpu_req, dma_req} <= 2'h0;
    endtask : prio
    task automatic complete_run();
        $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run
    initial begin
        {srst_i, int_wait, split, bytem, cpu_req, dma_req, we, word, addr, wdata} = {1'b1, 43'h0};
        {sel_ctl, port_out, wait_dis, wait_cnt, stall, hold_cnt, cycles} = {20'hF8F00, 4'h0, 64'h0};
        {hold_n, n_mismatch, n_compared, mux} = {1'b1, 68'h0};
        repeat (5) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        split  <= 1'b1;
        rw(20'h08010, 16'hA55A);
        rw(20'h08013, 16'h1234);
        split <= 1'b0;
        rw(20'h28006, 16'hC3B7);
        rw(20'h28009, 16'h5E71);
        repeat (9) @(negedge clk_sys_i);
        chk(a_o, 20'h2800A);
        chk(20'(cs_n), 20'hD);
        $display("test strobe styles and area change done");
        acc(1'b0, 1'b0, 1'b1, 20'h00400, 16'h0000);
        bytem <= 1'b1;
        repeat (3) @(negedge clk_sys_i);
        chk(20'(cs_n), 20'hF);
        chk(a_o, 20'h2800A);
        rw(20'h30004, 16'h9C2D);
        bytem <= 1'b0;
        repeat (3) @(negedge clk_sys_i);
        chk(20'(cs_n), 20'hB);
        $display("test internal access and byte bus done");
        acc(1'b0, 1'b0, 1'b1, 20'h40000, 16'h0000);
        l0 = lat;
        {wait_dis, wait_cnt} <= 12'h0C0;
        acc(1'b0, 1'b0, 1'b1, 20'h40000, 16'h0000);
        chk(20'(lat - l0), 20'd8);
        l1 = lat;
        acc(1'b0, 1'b0, 1'b1, 20'h00400, 16'h0000);
        l0 = lat;
        int_wait <= 1'b1;
        acc(1'b0, 1'b0, 1'b1, 20'h00400, 16'h0000);
        chk(20'(lat - l0), 20'd2);
        {int_wait, stall} <= 5'h08;
        rw(20'h40002, 16'h7E18);
        chk(20'(lat - l1), 20'd2);
        stall <= 4'h0;
        mux   <= 4'h4;
        acc(1'b0, 1'b0, 1'b1, 20'h30004, 16'h0000);
        chk(20'(got), 20'h0002D);
        chk(20'(mux_addr), 20'h00002);
        mux   <= 4'h0;
        $display("test wait states and ready done");
        prio(20'h40000, 0, 1'b1);
        prio(20'h40001, 4, 1'b0);
        hold_cnt <= 40;
        repeat (10) @(negedge clk_sys_i);
        chk(20'(grant_n), 20'h0);
        chk(20'({a_oe, s_oe}), 20'h0);
        acc(1'b0, 1'b0, 1'b1, 20'h40000, 16'h0000);
        chk(20'(lat > 25), 20'h1);
        chk(20'(grant_n), 20'h1);
        {sel_ctl, port_out} <= 8'h78;
        repeat (5) @(negedge clk_sys_i);
        chk(20'(cs_n), 20'hF);
        $display("test priority, hold and port pins done");
        complete_run();
    end
endmodule : external_bus_control_bench
`default_nettype wire
